// File: hw/block_mover.sv
// Address generation and sequencing of the pixel block mover
// What this block does
// - Linear copies move whole phrases, one per read and write cycle
// - Inner counter counts pixels; host sets outer count one for linear copies
// - Add control zero advances that pointer one phrase per access
// - Source read enable reads source; code 1100 copies; extra read if unaligned
// - Window address is X plus width times Y, without a multiplier
// - Width decodes as four-bit exponent and two mantissa bits, implicit one
// - Lines go in raster order; step value added after each line
// - Clipping suppresses writes outside the window yet keeps stepping
// - Expanded source bits mask painting; clear bits keep or paint background
// - Destination read keeps unpainted pixels; otherwise destination register is background
// - Expansion works per pixel always, per phrase at 8 and 16 bits
// - Bit selection counter resets whenever the inner loop exits
// - Rotation scans destination with second generator, source by fractional increments
// - In rotation, source window clipping gates destination writes
// - Status bit zero shows fully idle with last bus access done
`timescale 1ns/1ps
`default_nettype none
module block_mover (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic mem_valid,
	output var mover_pkg::mem_req_s mem_cmd,
	input wire logic mem_ack,
	input wire logic [63:0] mem_rdata
);
	mover_pkg::eng_s st_reg, st_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [23:0] win_pa, sec_pa, src_addr, dst_addr;
	logic [5:0] win_bo, sec_bo, src_off, dst_off, sh;
	logic rot, dph, clip_out, do_write, idle;
	logic [2:0] dpsz, idx;
	logic [3:0] fn;
	logic [6:0] ppp, off_pix, avail, npix, nbits;
	logic [63:0] ones, rmask, aligned, lfu, dstv, outd, pm, wdata;
	logic [127:0] combined;

	// ----------------------------------------------------------------
	// Address generators
	// ----------------------------------------------------------------
	window_addr u_win (
		.base(st_reg.wbase),
		.width_code(st_reg.wflags[mover_pkg::FL_WIDTH +: 6]),
		.psize(st_reg.wflags[mover_pkg::FL_PSIZE +: 3]),
		.x(st_reg.wptr.x),
		.y(st_reg.wptr.y),
		.phrase_addr(win_pa),
		.bit_off(win_bo)
	);

	window_addr u_sec (
		.base(st_reg.sbase),
		.width_code(st_reg.sflags[mover_pkg::FL_WIDTH +: 6]),
		.psize(st_reg.sflags[mover_pkg::FL_PSIZE +: 3]),
		.x(st_reg.sptr.x),
		.y(st_reg.sptr.y),
		.phrase_addr(sec_pa),
		.bit_off(sec_bo)
	);

	function automatic logic [15:0] step_x(input logic [15:0] x,
		input logic [9:0] fl);
		logic [15:0] pp;
		pp = 16'(mover_pkg::PHRASE_BITS >> fl[mover_pkg::FL_PSIZE +: 3]);
		step_x = fl[mover_pkg::FL_ADDC] ? x + 16'h1 : (x & ~(pp - 16'h1)) + pp;
	endfunction

	// ----------------------------------------------------------------
	// Data path
	// ----------------------------------------------------------------
	always_comb begin
		rot = st_reg.cmd[mover_pkg::CMD_ROTATE];
		// Rotation swaps roles: second generator writes, window reads
		dst_addr = rot ? sec_pa : win_pa;
		dst_off = rot ? sec_bo : win_bo;
		src_addr = rot ? win_pa : sec_pa;
		src_off = rot ? win_bo : sec_bo;
		dpsz = rot ? st_reg.sflags[mover_pkg::FL_PSIZE +: 3]
			: st_reg.wflags[mover_pkg::FL_PSIZE +: 3];
		dph = !rot && !st_reg.wflags[mover_pkg::FL_ADDC];
		ppp = 7'(mover_pkg::PHRASE_BITS >> dpsz);
		off_pix = 7'(dst_off >> dpsz);
		avail = ppp - off_pix;
		// Pixels covered by this write: phrase remainder capped by the inner count, or one pixel
		npix = !dph ? 7'h1 : (st_reg.inner < 17'(avail))
			? st_reg.inner[6:0] : avail;
		nbits = 7'(npix << dpsz);
		ones = nbits[6] ? 64'hFFFFFFFFFFFFFFFF : (64'h1 << nbits[5:0]) - 64'h1;
		rmask = ones << dst_off;
		// Realign source pixels onto destination lanes
		sh = (st_reg.cmd[mover_pkg::CMD_EXTRA_SOURCE_READ_FLAG] ? st_reg.xoff : src_off)
			- dst_off;
		combined = {st_reg.srcd,
			st_reg.cmd[mover_pkg::CMD_EXTRA_SOURCE_READ_FLAG] ? st_reg.srcp : st_reg.srcd};
		aligned = 64'(combined >> sh);
		fn = st_reg.cmd[mover_pkg::CMD_LFU +: 4];
		dstv = st_reg.cmd[mover_pkg::CMD_DSTEN] ? st_reg.dread
			: st_reg.dstd;
		lfu = ({64{fn[0]}} & ~aligned & ~dstv) | ({64{fn[1]}} & ~aligned & dstv)
			| ({64{fn[2]}} & aligned & ~dstv)
			| ({64{fn[3]}} & aligned & dstv);
		outd = st_reg.cmd[mover_pkg::CMD_PATSEL] ? st_reg.patd : lfu;
		pm = '1;
		idx = '0;
		if (st_reg.cmd[mover_pkg::CMD_EXPAND]) begin
			if (!dph) begin
				pm = {64{st_reg.srcd[st_reg.bitsel]}};
			end else if (dpsz == mover_pkg::PSIZE_8
				|| dpsz == mover_pkg::PSIZE_16) begin
				for (int j = 0; j < 8; j++) begin
					idx = st_reg.bitsel - off_pix[2:0]
						+ ((dpsz == mover_pkg::PSIZE_16) ? 3'(j >> 1) : 3'(j));
					pm[j*8 +: 8] = {8{st_reg.srcd[idx]}};
				end
			end
		end
		wdata = (outd & pm) | (dstv & ~pm);
		clip_out = st_reg.cmd[mover_pkg::CMD_CLIP]
			&& (st_reg.wptr.x[15] || st_reg.wptr.y[15]
			|| st_reg.wptr.x >= st_reg.wsize.x
			|| st_reg.wptr.y >= st_reg.wsize.y);
		// Pixel mode with destination read leaves clear-bit pixels alone
		do_write = !clip_out && !(st_reg.cmd[mover_pkg::CMD_EXPAND] && !dph
			&& st_reg.cmd[mover_pkg::CMD_DSTEN]
			&& !st_reg.srcd[st_reg.bitsel]);
		idle = st_reg.fsm == mover_pkg::ST_IDLE && !st_reg.mvalid;
	end

	// ----------------------------------------------------------------
	// Registers and sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		rdata_next = '0;
		if (reg_wr) begin
			case (reg_addr)
				mover_pkg::REG_WIN_BASE: st_next.wbase = reg_wdata[23:0];
				mover_pkg::REG_WIN_FLAGS: st_next.wflags = reg_wdata[9:0];
				mover_pkg::REG_WIN_SIZE: st_next.wsize = reg_wdata;
				mover_pkg::REG_WIN_PTR: st_next.wptr = reg_wdata;
				mover_pkg::REG_WIN_STEP: st_next.wstep = reg_wdata;
				mover_pkg::REG_WIN_FRAC: st_next.wfrac = reg_wdata;
				mover_pkg::REG_WIN_INC: st_next.winc = reg_wdata;
				mover_pkg::REG_WIN_FINC: st_next.wfinc = reg_wdata;
				mover_pkg::REG_WIN_FSTEP: st_next.wfstep = reg_wdata;
				mover_pkg::REG_SEC_BASE: st_next.sbase = reg_wdata[23:0];
				mover_pkg::REG_SEC_FLAGS: st_next.sflags = reg_wdata[9:0];
				mover_pkg::REG_SEC_PTR: st_next.sptr = reg_wdata;
				mover_pkg::REG_SEC_STEP: st_next.sstep = reg_wdata;
				mover_pkg::REG_COUNT: st_next.count = reg_wdata;
				mover_pkg::REG_SRC_LO: st_next.srcd[31:0] = reg_wdata;
				mover_pkg::REG_SRC_HI: st_next.srcd[63:32] = reg_wdata;
				mover_pkg::REG_DST_LO: st_next.dstd[31:0] = reg_wdata;
				mover_pkg::REG_DST_HI: st_next.dstd[63:32] = reg_wdata;
				mover_pkg::REG_PAT_LO: st_next.patd[31:0] = reg_wdata;
				mover_pkg::REG_PAT_HI: st_next.patd[63:32] = reg_wdata;
				mover_pkg::REG_CMD: begin
					if (idle) begin
						st_next.cmd = reg_wdata;
						st_next.inner = {st_reg.count[15:0] == 16'h0,
							st_reg.count[15:0]};
						st_next.outer = {st_reg.count[31:16] == 16'h0,
							st_reg.count[31:16]};
						st_next.bitsel = '0;
						st_next.fsm = (reg_wdata[mover_pkg::CMD_SOURCE_READ_ENABLE]
							&& reg_wdata[mover_pkg::CMD_EXTRA_SOURCE_READ_FLAG])
							? mover_pkg::ST_XREAD
							: reg_wdata[mover_pkg::CMD_SOURCE_READ_ENABLE] ? mover_pkg::ST_SREAD
							: reg_wdata[mover_pkg::CMD_DSTEN] ? mover_pkg::ST_DREAD
							: mover_pkg::ST_WRITE;
					end
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				mover_pkg::REG_WIN_PTR: rdata_next = st_reg.wptr;
				mover_pkg::REG_SEC_PTR: rdata_next = st_reg.sptr;
				mover_pkg::REG_CMD: rdata_next = st_reg.cmd;
				mover_pkg::REG_COUNT: rdata_next = st_reg.count;
				mover_pkg::REG_STATUS: rdata_next = {st_reg.inner[15:0], 12'h0,
					st_reg.fsm, idle};
				default: rdata_next = '0;
			endcase
		end
		case (st_reg.fsm)
			mover_pkg::ST_XREAD, mover_pkg::ST_SREAD, mover_pkg::ST_DREAD: begin
				if (!st_reg.mvalid) begin
					st_next.mvalid = 1'b1;
					st_next.mreq.we = 1'b0;
					st_next.mreq.addr = (st_reg.fsm == mover_pkg::ST_DREAD)
						? dst_addr : src_addr;
					st_next.mreq.data = '0;
					st_next.mreq.mask = '0;
				end else if (mem_ack) begin
					st_next.mvalid = 1'b0;
					if (st_reg.fsm == mover_pkg::ST_DREAD) begin
						st_next.dread = mem_rdata;
						st_next.fsm = mover_pkg::ST_WRITE;
					end else begin
						st_next.srcp = st_reg.srcd;
						st_next.srcd = mem_rdata;
					end
					if (st_reg.fsm == mover_pkg::ST_XREAD) begin
						// Extra read primes the source pipeline one phrase ahead
						st_next.xoff = src_off;
						st_next.sptr.x = step_x(st_reg.sptr.x, st_reg.sflags);
						st_next.fsm = mover_pkg::ST_SREAD;
					end else if (st_reg.fsm == mover_pkg::ST_SREAD) begin
						st_next.fsm = st_reg.cmd[mover_pkg::CMD_DSTEN]
							? mover_pkg::ST_DREAD : mover_pkg::ST_WRITE;
					end
				end
			end
			mover_pkg::ST_WRITE: begin
				if (!st_reg.mvalid && do_write) begin
					st_next.mvalid = 1'b1;
					st_next.mreq.we = 1'b1;
					st_next.mreq.addr = dst_addr;
					st_next.mreq.data = wdata;
					st_next.mreq.mask = rmask;
				end
				if ((!st_reg.mvalid && !do_write) || (st_reg.mvalid && mem_ack)) begin
					st_next.mvalid = 1'b0;
					if (rot) begin
						st_next.sptr.x = st_reg.sptr.x + 16'h1;
						{st_next.wptr.x, st_next.wfrac.x} = {st_reg.wptr.x,
							st_reg.wfrac.x} + {st_reg.winc.x, st_reg.wfinc.x};
						{st_next.wptr.y, st_next.wfrac.y} = {st_reg.wptr.y,
							st_reg.wfrac.y} + {st_reg.winc.y, st_reg.wfinc.y};
					end else begin
						st_next.wptr.x = step_x(st_reg.wptr.x, st_reg.wflags);
						if (st_reg.cmd[mover_pkg::CMD_SOURCE_READ_ENABLE]) begin
							st_next.sptr.x = step_x(st_reg.sptr.x, st_reg.sflags);
						end
					end
					st_next.inner = st_reg.inner - 17'(npix);
					st_next.bitsel = st_reg.bitsel + npix[2:0];
					st_next.fsm = (st_reg.inner <= 17'(npix)) ? mover_pkg::ST_STEP
						: st_reg.cmd[mover_pkg::CMD_SOURCE_READ_ENABLE] ? mover_pkg::ST_SREAD
						: st_reg.cmd[mover_pkg::CMD_DSTEN] ? mover_pkg::ST_DREAD
						: mover_pkg::ST_WRITE;
				end
			end
			mover_pkg::ST_STEP: begin
				st_next.sptr.x = st_reg.sptr.x + st_reg.sstep.x;
				st_next.sptr.y = st_reg.sptr.y + st_reg.sstep.y;
				{st_next.wptr.x, st_next.wfrac.x} = {st_reg.wptr.x, st_reg.wfrac.x}
					+ {st_reg.wstep.x, st_reg.wfstep.x};
				{st_next.wptr.y, st_next.wfrac.y} = {st_reg.wptr.y, st_reg.wfrac.y}
					+ {st_reg.wstep.y, st_reg.wfstep.y};
				st_next.bitsel = '0;
				st_next.inner = {st_reg.count[15:0] == 16'h0, st_reg.count[15:0]};
				st_next.outer = st_reg.outer - 17'h1;
				st_next.fsm = (st_reg.outer <= 17'h1) ? mover_pkg::ST_IDLE
					: st_reg.cmd[mover_pkg::CMD_EXTRA_SOURCE_READ_FLAG] ? mover_pkg::ST_XREAD
					: st_reg.cmd[mover_pkg::CMD_SOURCE_READ_ENABLE] ? mover_pkg::ST_SREAD
					: st_reg.cmd[mover_pkg::CMD_DSTEN] ? mover_pkg::ST_DREAD
					: mover_pkg::ST_WRITE;
			end
			mover_pkg::ST_IDLE: ;
			default: st_next.fsm = mover_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_reg <= mover_pkg::ENG_RESET;
			rdata_reg <= '0;
		end else begin
			st_reg <= st_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign mem_valid = st_reg.mvalid;
	assign mem_cmd = st_reg.mreq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	phrase_addr_a: assert property (mem_valid |-> mem_cmd.addr[2:0] == 3'h0)
		else $error("bus address not phrase aligned");
	hold_req_a: assert property (mem_valid && !mem_ack
		|=> mem_valid && $stable(mem_cmd))
		else $error("request dropped or changed before acknowledge");
	busy_cmd_a: assert property (reg_wr && reg_addr == mover_pkg::REG_CMD
		&& !idle |=> $stable(st_reg.cmd))
		else $error("command taken while busy");
	start_a: assert property (reg_wr && reg_addr == mover_pkg::REG_CMD
		&& idle |=> st_reg.fsm != mover_pkg::ST_IDLE)
		else $error("command write did not start");
	idle_flag_a: assert property (reg_rd && reg_addr == mover_pkg::REG_STATUS
		|=> reg_rdata[mover_pkg::STAT_IDLE] == $past(idle))
		else $error("idle status wrong");
	clip_gate_a: assert property (mem_valid && mem_cmd.we
		|-> !clip_out)
		else $error("write issued outside clip window");
	bit_reset_a: assert property (st_reg.fsm == mover_pkg::ST_STEP
		|=> st_reg.bitsel == 3'h0)
		else $error("bit selection not reset at line end");
	copy_code_a: assert property (fn == mover_pkg::LFU_COPY |-> lfu == aligned)
		else $error("copy code does not pass source");
	last_line_a: assert property (st_reg.fsm == mover_pkg::ST_STEP
		&& st_reg.outer == 17'h1 |=> st_reg.fsm == mover_pkg::ST_IDLE)
		else $error("operation ran past its last line");

	line_step_c: cover property (st_reg.fsm == mover_pkg::ST_STEP
		&& st_reg.outer > 17'h1);
	rot_write_c: cover property (rot && mem_valid && mem_cmd.we && mem_ack);
	clip_skip_c: cover property (st_reg.fsm == mover_pkg::ST_WRITE && clip_out);
	expand_phrase_c: cover property (mem_valid && mem_cmd.we
		&& st_reg.cmd[mover_pkg::CMD_EXPAND] && dph);
endmodule
`default_nettype wire

// File: hw/mover_pkg.sv
// Shared constants, states and carriers for the pixel block mover
package mover_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 64;
	localparam int PHRASE_BITS = 64;
	localparam int FLAG_W = 10;

	// ----------------------------------------------------------------
	// Register indices on the software port
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_WIN_BASE = 5'h00;
	localparam logic [4:0] REG_WIN_FLAGS = 5'h01;
	localparam logic [4:0] REG_WIN_SIZE = 5'h02;
	localparam logic [4:0] REG_WIN_PTR = 5'h03;
	localparam logic [4:0] REG_WIN_STEP = 5'h04;
	localparam logic [4:0] REG_WIN_FRAC = 5'h05;
	localparam logic [4:0] REG_WIN_INC = 5'h06;
	localparam logic [4:0] REG_WIN_FINC = 5'h07;
	localparam logic [4:0] REG_WIN_FSTEP = 5'h08;
	localparam logic [4:0] REG_SEC_BASE = 5'h09;
	localparam logic [4:0] REG_SEC_FLAGS = 5'h0A;
	localparam logic [4:0] REG_SEC_PTR = 5'h0B;
	localparam logic [4:0] REG_SEC_STEP = 5'h0C;
	localparam logic [4:0] REG_COUNT = 5'h0D;
	localparam logic [4:0] REG_CMD = 5'h0E;
	localparam logic [4:0] REG_STATUS = 5'h0F;
	localparam logic [4:0] REG_SRC_LO = 5'h10;
	localparam logic [4:0] REG_SRC_HI = 5'h11;
	localparam logic [4:0] REG_DST_LO = 5'h12;
	localparam logic [4:0] REG_DST_HI = 5'h13;
	localparam logic [4:0] REG_PAT_LO = 5'h14;
	localparam logic [4:0] REG_PAT_HI = 5'h15;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FL_ADDC = 0;
	localparam int FL_PSIZE = 1;
	localparam int FL_WIDTH = 4;
	localparam int CMD_SOURCE_READ_ENABLE = 0;
	localparam int CMD_EXTRA_SOURCE_READ_FLAG = 1;
	localparam int CMD_DSTEN = 2;
	localparam int CMD_CLIP = 3;
	localparam int CMD_EXPAND = 4;
	localparam int CMD_ROTATE = 5;
	localparam int CMD_PATSEL = 16;
	localparam int CMD_LFU = 21;
	localparam int STAT_IDLE = 0;
	localparam logic [3:0] LFU_COPY = 4'hC;
	localparam logic [2:0] PSIZE_8 = 3'h3;
	localparam logic [2:0] PSIZE_16 = 3'h4;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SREAD = 3'h1,
		ST_DREAD = 3'h3,
		ST_WRITE = 3'h2,
		ST_STEP = 3'h6,
		ST_XREAD = 3'h4
	} blit_state_e;

	typedef struct packed {
		logic [15:0] y;
		logic [15:0] x;
	} xy_s;

	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [DATA_W-1:0] mask;
	} mem_req_s;

	typedef struct packed {
		blit_state_e fsm;
		logic mvalid;
		mem_req_s mreq;
		logic [ADDR_W-1:0] wbase;
		logic [ADDR_W-1:0] sbase;
		logic [FLAG_W-1:0] wflags;
		logic [FLAG_W-1:0] sflags;
		xy_s wsize;
		xy_s wptr;
		xy_s wfrac;
		xy_s wstep;
		xy_s wfstep;
		xy_s winc;
		xy_s wfinc;
		xy_s sptr;
		xy_s sstep;
		logic [31:0] count;
		logic [31:0] cmd;
		logic [16:0] inner;
		logic [16:0] outer;
		logic [DATA_W-1:0] srcd;
		logic [DATA_W-1:0] srcp;
		logic [DATA_W-1:0] dstd;
		logic [DATA_W-1:0] patd;
		logic [DATA_W-1:0] dread;
		logic [2:0] bitsel;
		logic [5:0] xoff;
	} eng_s;

	localparam eng_s ENG_RESET = '0;

endpackage

// File: hw/window_addr.sv
// Pixel to phrase address translation for one address generator
`timescale 1ns/1ps
`default_nettype none
module window_addr (
	input wire logic [23:0] base,
	input wire logic [5:0] width_code,
	input wire logic [2:0] psize,
	input wire logic [15:0] x,
	input wire logic [15:0] y,
	output logic [23:0] phrase_addr,
	output logic [5:0] bit_off
);
	logic signed [31:0] ys;
	logic signed [31:0] scaled;
	logic signed [31:0] pix;
	logic signed [31:0] bits;

	// Width is 1.mm x 2^eeee, so width*y is shifts and adds only
	always_comb begin
		ys = 32'(signed'(y));
		scaled = (ys <<< 2) + (width_code[1] ? (ys <<< 1) : 32'sh0)
			+ (width_code[0] ? ys : 32'sh0);
		scaled = (scaled <<< width_code[5:2]) >>> 2;
		pix = scaled + 32'(signed'(x));
		bits = pix <<< psize;
		phrase_addr = base + {bits[26:6], 3'h0};
		bit_off = bits[5:0];
	end
endmodule
`default_nettype wire

// File: tb/block_mover_bench.sv
// Self-checking bench for the pixel block mover
`timescale 1ns/1ps
`default_nettype none
module block_mover_bench;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic mem_valid;
	mover_pkg::mem_req_s mem_cmd;
	logic mem_ack;
	logic [63:0] mem_rdata;
	logic slow = 1'b0;
	int error_cnt = 0;
	int checked = 0;
	localparam logic [31:0] LFU = 32'(mover_pkg::LFU_COPY) << mover_pkg::CMD_LFU;

	always #2 clock = ~clock;

	block_mover u_block_mover (.clock(clock), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_valid(mem_valid),
		.mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	mem_model u_mem_model (.clock(clock), .slow(slow),
		.mem_valid(mem_valid), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));

	// ----------------------------------------------------------------
	// Bus and compare helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic wait_idle();
		logic [31:0] s;
		s = 32'h0;
		for (int i = 0; i < 300 && s[0] !== 1'b1; i++) begin
			rd(mover_pkg::REG_STATUS, s);
		end
		chk("status", 64'h1, 64'(s[3:0]));
	endtask

	function automatic logic [7:0] pix(input int a);
		return u_mem_model.mem[a[12:3]][8 * a[2:0] +: 8];
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		rd(mover_pkg::REG_STATUS, d);
		chk("reset status", 64'h1, 64'(d));
		@(posedge clock);
		#1;
		chk("rdata after read", 64'h0, 64'(reg_rdata));
		rd(5'h1F, d);
		chk("unmapped read", 64'h0, 64'(d));
	endtask

	task automatic t_copy();
		logic [63:0] s0;
		logic [63:0] s1;
		int r0;
		int w0;
		s0 = u_mem_model.mem[32];
		s1 = u_mem_model.mem[33];
		r0 = u_mem_model.reads;
		w0 = u_mem_model.writes;
		slow <= 1'b1;
		wr(mover_pkg::REG_SEC_BASE, 32'h100);
		wr(mover_pkg::REG_WIN_BASE, 32'h200);
		wr(mover_pkg::REG_SEC_FLAGS, 32'h116);
		wr(mover_pkg::REG_WIN_FLAGS, 32'h116);
		wr(mover_pkg::REG_SEC_PTR, 32'h0);
		wr(mover_pkg::REG_WIN_PTR, 32'h0);
		wr(mover_pkg::REG_COUNT, 32'h0001_0010);
		wr(mover_pkg::REG_CMD, LFU | 32'h1);
		wr(mover_pkg::REG_CMD, LFU | 32'h5);
		wait_idle();
		chk("copy reads", 64'h2, 64'(u_mem_model.reads - r0));
		chk("copy writes", 64'h2, 64'(u_mem_model.writes - w0));
		chk("copy phrase 0", s0, u_mem_model.mem[64]);
		chk("copy phrase 1", s1, u_mem_model.mem[65]);
		slow <= 1'b0;
	endtask

	// One phrase from a source three pixels past a phrase boundary
	task automatic t_shift();
		logic [63:0] lo;
		logic [63:0] hi;
		int r0;
		lo = u_mem_model.mem[32];
		hi = u_mem_model.mem[33];
		r0 = u_mem_model.reads;
		wr(mover_pkg::REG_SEC_BASE, 32'h100);
		wr(mover_pkg::REG_WIN_BASE, 32'h300);
		wr(mover_pkg::REG_SEC_FLAGS, 32'h116);
		wr(mover_pkg::REG_WIN_FLAGS, 32'h116);
		wr(mover_pkg::REG_SEC_PTR, 32'h3);
		wr(mover_pkg::REG_WIN_PTR, 32'h0);
		wr(mover_pkg::REG_COUNT, 32'h0001_0008);
		wr(mover_pkg::REG_CMD, LFU | 32'h3);
		wait_idle();
		chk("shift reads", 64'h2, 64'(u_mem_model.reads - r0));
		chk("shift phrase", {hi[23:0], lo[63:24]},
			u_mem_model.mem[96]);
	endtask

	// Two by two rectangle at (2,1); the window is three pixels wide
	task automatic t_rect(input logic [5:0] code, input int w);
		logic [7:0] old [4];
		int w0;
		int a;
		for (int k = 0; k < 4; k++) begin
			old[k] = pix(32'h802 + k % 2 + w * (1 + k / 2));
		end
		w0 = u_mem_model.writes;
		wr(mover_pkg::REG_WIN_BASE, 32'h800);
		wr(mover_pkg::REG_SEC_BASE, 32'h400);
		wr(mover_pkg::REG_WIN_FLAGS, {22'h0, code, 4'h7});
		wr(mover_pkg::REG_SEC_FLAGS, {22'h0, code, 4'h7});
		wr(mover_pkg::REG_WIN_PTR, 32'h0001_0002);
		wr(mover_pkg::REG_SEC_PTR, 32'h0);
		wr(mover_pkg::REG_WIN_STEP, 32'h0001_FFFE);
		wr(mover_pkg::REG_SEC_STEP, 32'h0001_FFFE);
		wr(mover_pkg::REG_WIN_SIZE, 32'h0004_0003);
		wr(mover_pkg::REG_COUNT, 32'h0002_0002);
		wr(mover_pkg::REG_CMD, LFU | 32'h9);
		wait_idle();
		for (int k = 0; k < 4; k++) begin
			a = 32'h802 + k % 2 + w * (1 + k / 2);
			chk("rect pixel", (k % 2) ? old[k] : pix(32'h400 + w * (k / 2)),
				pix(a));
		end
		chk("rect writes", 64'h2, 64'(u_mem_model.writes - w0));
	endtask

	// Three pixels a line over two lines, mask bits 1,0,0 on each line
	task automatic t_expand(input logic dsten, input logic addc);
		logic [7:0] old [6];
		int a;
		for (int k = 0; k < 6; k++) begin
			old[k] = pix(32'h1800 + k % 3 + 20 * (k / 3));
		end
		wr(mover_pkg::REG_WIN_BASE, 32'h1800);
		wr(mover_pkg::REG_WIN_FLAGS, {22'h0, 6'h11, 3'h3, addc});
		wr(mover_pkg::REG_WIN_PTR, 32'h0);
		wr(mover_pkg::REG_WIN_STEP,
			addc ? 32'h0001_FFFD : 32'h0001_FFF8);
		wr(mover_pkg::REG_COUNT, 32'h0002_0003);
		wr(mover_pkg::REG_SRC_LO, 32'h9999_9999);
		wr(mover_pkg::REG_SRC_HI, 32'h9999_9999);
		wr(mover_pkg::REG_PAT_LO, 32'hAAAA_AAAA);
		wr(mover_pkg::REG_PAT_HI, 32'hAAAA_AAAA);
		wr(mover_pkg::REG_DST_LO, 32'h5555_5555);
		wr(mover_pkg::REG_DST_HI, 32'h5555_5555);
		wr(mover_pkg::REG_CMD, 32'h0001_0010 | {29'h0, dsten, 2'h0});
		wait_idle();
		for (int k = 0; k < 6; k++) begin
			a = 32'h1800 + k % 3 + 20 * (k / 3);
			chk("paint pixel", (k % 3 == 0) ? 8'hAA : (dsten ? old[k] : 8'h55),
				pix(a));
		end
	endtask

	// Two by two turn: source columns become destination lines
	task automatic t_turn();
		logic [7:0] old [2];
		int w0;
		old[0] = pix(32'h1D14);
		old[1] = pix(32'h1D15);
		w0 = u_mem_model.writes;
		wr(mover_pkg::REG_WIN_BASE, 32'h400);
		wr(mover_pkg::REG_SEC_BASE, 32'h1D00);
		wr(mover_pkg::REG_WIN_FLAGS, 32'h117);
		wr(mover_pkg::REG_SEC_FLAGS, 32'h117);
		wr(mover_pkg::REG_WIN_PTR, 32'h0);
		wr(mover_pkg::REG_SEC_PTR, 32'h0);
		wr(mover_pkg::REG_WIN_INC, 32'h0001_0000);
		wr(mover_pkg::REG_WIN_STEP, 32'hFFFE_0001);
		wr(mover_pkg::REG_SEC_STEP, 32'h0001_FFFE);
		wr(mover_pkg::REG_WIN_SIZE, 32'h0002_0001);
		wr(mover_pkg::REG_COUNT, 32'h0002_0002);
		wr(mover_pkg::REG_CMD, LFU | 32'h29);
		wait_idle();
		chk("turn pixel 0", pix(32'h400), pix(32'h1D00));
		chk("turn pixel 1", pix(32'h414), pix(32'h1D01));
		chk("turn clipped 0", old[0], pix(32'h1D14));
		chk("turn clipped 1", old[1], pix(32'h1D15));
		chk("turn writes", 64'h2, 64'(u_mem_model.writes - w0));
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#200000;
		error_cnt++;
		conclude();
	end

	initial begin
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_copy();
		t_shift();
		t_rect(6'h11, 20);
		t_rect(6'h25, 640);
		t_expand(1'b1, 1'b1);
		t_expand(1'b0, 1'b1);
		t_expand(1'b1, 1'b0);
		t_expand(1'b0, 1'b0);
		t_turn();
		conclude();
	end
endmodule
`default_nettype wire

// File: tb/mem_model.sv
// Shared memory partner answering phrase requests of the block mover
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input wire logic clock,
	input wire logic slow,
	input wire logic mem_valid,
	input wire mover_pkg::mem_req_s mem_cmd,
	output logic mem_ack,
	output logic [63:0] mem_rdata
);
	logic [63:0] mem [0:1023];
	int wait_cnt = 0;
	int reads = 0;
	int writes = 0;

	initial begin
		mem_ack = 1'b0;
		mem_rdata = 64'h0;
		for (int i = 0; i < 1024; i++) begin
			mem[i] = 64'h0123456789ABCDEF * 64'(i + 1);
		end
	end

	// Read data is only good in the ack cycle; it toggles otherwise
	always @(posedge clock) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_valid && !mem_ack) begin
			if (wait_cnt >= (slow ? 3 : 0)) begin
				wait_cnt <= 0;
				mem_ack <= 1'b1;
				if (mem_cmd.we) begin
					writes <= writes + 1;
					mem[mem_cmd.addr[12:3]] <= (mem[mem_cmd.addr[12:3]]
						& ~mem_cmd.mask) | (mem_cmd.data & mem_cmd.mask);
				end else begin
					reads <= reads + 1;
					mem_rdata <= mem[mem_cmd.addr[12:3]];
				end
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end
	end
endmodule
`default_nettype wire
